// ===== hdl/dma_core_regs.svh
// register offsets, field positions, reset values and codes of the dma transfer core
`ifndef DMA_CORE_REGS_SVH
`define DMA_CORE_REGS_SVH

// per-channel registers: byte address = channel * 0x20 + offset * 4
`define CH_SRC_OFS        3'h0
`define CH_DST_OFS        3'h1
`define CH_CNT_OFS        3'h2
`define CH_SFC_OFS        3'h3
`define CH_MODE_OFS       3'h4
`define CH_REGION_LAST    10'h0BF

// shared registers (byte addresses)
`define G_IDXA_ADDR       10'h0C0
`define G_IDXB_ADDR       10'h0C4
`define G_FRIA_ADDR       10'h0C8
`define G_FRIB_ADDR       10'h0CC
`define G_GSA_ADDR        10'h0D0
`define G_GDA_ADDR        10'h0D4
`define G_GCR_ADDR        10'h0D8
`define G_GFR_ADDR        10'h0DC
`define G_CTRL_ADDR       10'h0E0
`define G_STATUS_ADDR     10'h0E4

// channel_mode_control fields
`define MODE_AUTO_BIT     15
`define MODE_IRQEN_BIT    14
`define MODE_IRQ_MODE_SELECT_BIT     13
`define MODE_ABU_BIT      12
`define MODE_DWORD_BIT    11
`define MODE_SMODE_LSB    8
`define MODE_SOURCE_INDEX_SELECT_BIT     7
`define MODE_DMODE_LSB    2
`define MODE_DEST_INDEX_SELECT_BIT     1

// sync_and_frame_count fields
`define SFC_SYNC_LSB      12
`define SFC_FRAME_LSB     0

// control register fields
`define CTRL_EN_LSB       0
`define CTRL_HI_LSB       8

// status register fields
`define STAT_BUSY_BIT     8
`define STAT_CH_LSB       12

// sync event codes
`define SYNC_NONE         4'h0
`define SYNC_SER0_RX      4'h1
`define SYNC_SER0_TX      4'h2
`define SYNC_SER2_RX      4'h3
`define SYNC_SER2_TX      4'h4
`define SYNC_SER1_RX      4'h5
`define SYNC_SER1_TX      4'h6
`define SYNC_TIMER        4'hD
`define SYNC_EXT3         4'hE

// reset values
`define RST_WORD          16'h0000
`define RST_FRAME         8'h00

`endif

// ===== hdl/dma_core_pkg.sv
// types shared by the dma transfer core and its arbiter
package dma_core_pkg;

  `include "dma_core_regs.svh"

  localparam int NCH = 6;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } xfer_state_t;

  typedef enum logic [1:0] {
    AM_KEEP = 2'h0,
    AM_INC  = 2'h1,
    AM_DEC  = 2'h2,
    AM_IDX  = 2'h3
  } addr_mode_t;

  typedef struct packed {
    logic [NCH-1:0][15:0] src;
    logic [NCH-1:0][15:0] dst;
    logic [NCH-1:0][15:0] cnt;
    logic [NCH-1:0][15:0] elem_len;
    logic [NCH-1:0][15:0] mode;
    logic [NCH-1:0][3:0]  sync_sel;
    logic [NCH-1:0][7:0]  frames;
    logic [15:0]          idx_a;
    logic [15:0]          idx_b;
    logic [15:0]          fri_a;
    logic [15:0]          fri_b;
    logic [15:0]          gsa;
    logic [15:0]          gda;
    logic [15:0]          gcr;
    logic [7:0]           gfr;
    logic [NCH-1:0]       enable;
    logic [NCH-1:0]       high_prio;
    logic [NCH-1:0]       sync_pend;
    logic [NCH-1:0]       irq;
    xfer_state_t          st;
    logic [2:0]           ch;
    logic                 half;
    logic [15:0]          data;
    logic [15:0]          mem_addr;
    logic                 ack;
    logic [31:0]          rdata;
  } core_state_t;

  typedef struct packed {
    logic [2:0] ptr_hi;
    logic [2:0] ptr_lo;
  } arb_state_t;

endpackage : dma_core_pkg

// ===== hdl/dma_arb_if.sv
// request and grant signals between the transfer core and its arbiter
interface dma_arb_if;
  logic [5:0] req;
  logic [5:0] high;
  logic       take;
  logic       grant_valid;
  logic [2:0] grant_ch;

  modport arb (input req, input high, input take, output grant_valid, output grant_ch);
  modport core (output req, output high, output take, input grant_valid, input grant_ch);
endinterface : dma_arb_if

// ===== hdl/dma_channel_arbiter.sv
// two-level priority arbiter with round robin inside each level
module dma_channel_arbiter
  import dma_core_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic ce_in,
  dma_arb_if.arb    arb
);

  arb_state_t s;
  arb_state_t next_s;
  logic       hi_found;
  logic [2:0] hi_idx;
  logic       lo_found;
  logic [2:0] lo_idx;

  // first requester after the pointer, wrapping over six channels
  function automatic logic [3:0] pick(input logic [5:0] req, input logic [2:0] ptr);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = 6; i >= 1; i--) begin
      idx = 3'((int'(ptr) + i) % 6);
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction : pick

  assign {hi_found, hi_idx} = pick(arb.req & arb.high, s.ptr_hi);
  assign {lo_found, lo_idx} = pick(arb.req & ~arb.high, s.ptr_lo);

  // high level always beats low level
  assign arb.grant_valid = hi_found | lo_found;
  assign arb.grant_ch    = hi_found ? hi_idx : lo_idx;

  // rotate the pointer of the served level
  always_comb begin
    next_s = s;
    if (arb.take && hi_found) begin
      next_s.ptr_hi = hi_idx;
    end else if (arb.take && lo_found) begin
      next_s.ptr_lo = lo_idx;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s <= '{ptr_hi: 3'h5, ptr_lo: 3'h5};
    end else if (ce_in) begin
      s <= next_s;
    end
  end

endmodule : dma_channel_arbiter

// ===== hdl/multichannel_dma_transfer_core.sv
// six-channel dma transfer core with avalon-mm register slave
module multichannel_dma_transfer_core
  import dma_core_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic      [15:0] mem_addr_out,
  output logic             mem_read_out,
  output logic             mem_write_out,
  output logic      [15:0] mem_wdata_out,
  input  wire logic [15:0] mem_rdata_in,
  input  wire logic        mem_ready_in,
  input  wire logic [2:0]  serial_rx_event_in,
  input  wire logic [2:0]  serial_tx_event_in,
  input  wire logic        timer_event_in,
  input  wire logic        ext_irq3_event_in,
  output logic      [5:0]  channel_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state and arbiter

  core_state_t s;
  core_state_t next_s;
  dma_arb_if   arb_bus ();

  dma_channel_arbiter u_arbiter (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .arb        (arb_bus.arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // post-modification of one address
  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic [1:0] m,
                                            input logic [15:0] step);
    logic [15:0] r;
    r = a;
    unique case (addr_mode_t'(m))
      AM_KEEP: r = a;
      AM_INC:  r = a + 16'h0001;
      AM_DEC:  r = a - 16'h0001;
      AM_IDX:  r = a + step;
    endcase
    return r;
  endfunction : next_addr

  // element or frame index of the selected pair
  function automatic logic [15:0] pick_step(input logic sel, input logic last,
                                            input core_state_t c);
    logic [15:0] r;
    r = sel ? (last ? c.fri_b : c.idx_b) : (last ? c.fri_a : c.idx_a);
    return r;
  endfunction : pick_step

  // true when the selected sync event fires
  function automatic logic sync_hit(input logic [3:0] sel, input logic [2:0] rx,
                                    input logic [2:0] tx, input logic tmr, input logic ext);
    logic r;
    r = 1'b0;
    case (sel)
      `SYNC_SER0_RX: r = rx[0];
      `SYNC_SER0_TX: r = tx[0];
      `SYNC_SER2_RX: r = rx[2];
      `SYNC_SER2_TX: r = tx[2];
      `SYNC_SER1_RX: r = rx[1];
      `SYNC_SER1_TX: r = tx[1];
      `SYNC_TIMER:   r = tmr;
      `SYNC_EXT3:    r = ext;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction : sync_hit

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  // combinational outputs

  logic        bus_req;
  logic        bus_do;
  logic [2:0]  reg_ch;
  logic [2:0]  reg_k;
  logic        in_ch_region;
  logic [15:0] cur_mode;
  logic        dword;
  logic        last_xfer;

  assign bus_req             = avs_read_in | avs_write_in;
  assign bus_do              = bus_req & ~s.ack;
  assign avs_waitrequest_out = bus_do;
  assign avs_readdata_out    = s.rdata;
  assign reg_ch              = avs_address_in[7:5];
  assign reg_k               = avs_address_in[4:2];
  assign in_ch_region        = (avs_address_in <= `CH_REGION_LAST) && (reg_ch < 3'(NCH));

  assign mem_addr_out    = s.mem_addr;
  assign mem_read_out    = (s.st == ST_READ);
  assign mem_write_out   = (s.st == ST_WRITE);
  assign mem_wdata_out   = s.data;
  assign channel_irq_out = s.irq;

  assign cur_mode  = s.mode[s.ch];
  assign dword     = cur_mode[`MODE_DWORD_BIT];
  // last transfer of a frame: last element and, in double-word, its second half
  assign last_xfer = (s.cnt[s.ch] == 16'h0000) && (!dword || s.half);

  // requests: enabled channels whose sync condition is met
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      arb_bus.req[i] = s.enable[i] && ((s.sync_sel[i] == `SYNC_NONE) || s.sync_pend[i]);
    end
  end
  assign arb_bus.high = s.high_prio;
  assign arb_bus.take = (s.st == ST_IDLE) && arb_bus.grant_valid;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0]  c;
    logic [15:0] m;
    logic [15:0] half_pt;
    logic        irq_en;
    c       = s.ch;
    m       = cur_mode;
    half_pt = 16'(s.elem_len[s.ch] >> 1);
    irq_en  = m[`MODE_IRQEN_BIT];
    next_s  = s;
    next_s.irq = '0;

    // sync events latch until the channel is granted; set wins over clear
    for (int i = 0; i < NCH; i++) begin
      if (arb_bus.take && arb_bus.grant_ch == 3'(i)) begin
        next_s.sync_pend[i] = 1'b0;
      end
      if (sync_hit(s.sync_sel[i], serial_rx_event_in, serial_tx_event_in,
                   timer_event_in, ext_irq3_event_in)) begin
        next_s.sync_pend[i] = 1'b1;
      end
    end

    // transfer engine
    unique case (s.st)
      ST_IDLE: begin
        if (arb_bus.take) begin
          next_s.ch       = arb_bus.grant_ch;
          next_s.half     = 1'b0;
          next_s.mem_addr = s.src[arb_bus.grant_ch];
          next_s.st       = ST_READ;
        end
      end
      ST_READ: begin
        if (mem_ready_in) begin
          next_s.data = mem_rdata_in;
          next_s.src[c] = next_addr(s.src[c], m[`MODE_SMODE_LSB +: 2],
                                    pick_step(m[`MODE_SOURCE_INDEX_SELECT_BIT], last_xfer, s));
          next_s.mem_addr = s.dst[c];
          next_s.st       = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (mem_ready_in) begin
          next_s.dst[c] = next_addr(s.dst[c], m[`MODE_DMODE_LSB +: 2],
                                    pick_step(m[`MODE_DEST_INDEX_SELECT_BIT], last_xfer, s));
          if (dword && !s.half) begin
            // first half of a pair: go on at once with the second
            next_s.half     = 1'b1;
            next_s.mem_addr = next_s.src[c];
            next_s.st       = ST_READ;
          end else begin
            next_s.st = ST_IDLE;
            if (s.cnt[c] != 16'h0000) begin
              next_s.cnt[c] = s.cnt[c] - 16'h0001;
              if (m[`MODE_ABU_BIT] && m[`MODE_IRQ_MODE_SELECT_BIT] && irq_en
                  && (s.cnt[c] - 16'h0001) == half_pt) begin
                next_s.irq[c] = 1'b1;
              end
            end else if (m[`MODE_ABU_BIT]) begin
              // full buffer: wrap around and keep running
              next_s.cnt[c] = s.elem_len[c];
              next_s.src[c] = s.gsa;
              next_s.dst[c] = s.gda;
              next_s.irq[c] = irq_en;
            end else if (s.frames[c] != 8'h00) begin
              next_s.frames[c] = s.frames[c] - 8'h01;
              next_s.cnt[c]    = s.elem_len[c];
              next_s.irq[c]    = irq_en && m[`MODE_IRQ_MODE_SELECT_BIT];
            end else begin
              next_s.irq[c] = irq_en;
              if (m[`MODE_AUTO_BIT]) begin
                next_s.src[c]      = s.gsa;
                next_s.dst[c]      = s.gda;
                next_s.cnt[c]      = s.gcr;
                next_s.elem_len[c] = s.gcr;
                next_s.frames[c]   = s.gfr;
              end else begin
                next_s.enable[c] = 1'b0;
              end
            end
          end
        end
      end
      default: next_s.st = ST_IDLE;
    endcase

    // register slave: one wait cycle, then the answer
    next_s.ack = bus_do;
    if (bus_do && avs_read_in) begin
      next_s.rdata = 32'h0000_0000;
      if (in_ch_region) begin
        unique case (reg_k)
          `CH_SRC_OFS:  next_s.rdata[15:0] = s.src[reg_ch];
          `CH_DST_OFS:  next_s.rdata[15:0] = s.dst[reg_ch];
          `CH_CNT_OFS:  next_s.rdata[15:0] = s.cnt[reg_ch];
          `CH_SFC_OFS:  next_s.rdata[15:0] = {s.sync_sel[reg_ch], 4'h0, s.frames[reg_ch]};
          `CH_MODE_OFS: next_s.rdata[15:0] = s.mode[reg_ch];
          default:      next_s.rdata = 32'h0000_0000;
        endcase
      end else begin
        case (avs_address_in)
          `G_IDXA_ADDR:   next_s.rdata[15:0] = s.idx_a;
          `G_IDXB_ADDR:   next_s.rdata[15:0] = s.idx_b;
          `G_FRIA_ADDR:   next_s.rdata[15:0] = s.fri_a;
          `G_FRIB_ADDR:   next_s.rdata[15:0] = s.fri_b;
          `G_GSA_ADDR:    next_s.rdata[15:0] = s.gsa;
          `G_GDA_ADDR:    next_s.rdata[15:0] = s.gda;
          `G_GCR_ADDR:    next_s.rdata[15:0] = s.gcr;
          `G_GFR_ADDR:    next_s.rdata[7:0]  = s.gfr;
          `G_CTRL_ADDR:   next_s.rdata[15:0] = {2'h0, s.high_prio, 2'h0, s.enable};
          `G_STATUS_ADDR: next_s.rdata[15:0] = {1'b0, s.ch, 3'h0, s.st != ST_IDLE,
                                                2'h0, s.enable};
          default:        next_s.rdata = 32'h0000_0000;
        endcase
      end
    end
    // software writes are applied last and win over engine updates
    if (bus_do && avs_write_in) begin
      if (in_ch_region) begin
        unique case (reg_k)
          `CH_SRC_OFS: next_s.src[reg_ch] = merge16(s.src[reg_ch], avs_writedata_in,
                                                    avs_byteenable_in);
          `CH_DST_OFS: next_s.dst[reg_ch] = merge16(s.dst[reg_ch], avs_writedata_in,
                                                    avs_byteenable_in);
          `CH_CNT_OFS: begin
            next_s.cnt[reg_ch] = merge16(s.cnt[reg_ch], avs_writedata_in, avs_byteenable_in);
            next_s.elem_len[reg_ch] = next_s.cnt[reg_ch];
          end
          `CH_SFC_OFS: begin
            if (avs_byteenable_in[0]) begin
              next_s.frames[reg_ch] = avs_writedata_in[7:0];
            end
            if (avs_byteenable_in[1]) begin
              next_s.sync_sel[reg_ch] = avs_writedata_in[`SFC_SYNC_LSB +: 4];
            end
          end
          `CH_MODE_OFS: next_s.mode[reg_ch] = merge16(s.mode[reg_ch], avs_writedata_in,
                                                      avs_byteenable_in);
          default: next_s.ack = bus_do;
        endcase
      end else begin
        case (avs_address_in)
          `G_IDXA_ADDR: next_s.idx_a = merge16(s.idx_a, avs_writedata_in, avs_byteenable_in);
          `G_IDXB_ADDR: next_s.idx_b = merge16(s.idx_b, avs_writedata_in, avs_byteenable_in);
          `G_FRIA_ADDR: next_s.fri_a = merge16(s.fri_a, avs_writedata_in, avs_byteenable_in);
          `G_FRIB_ADDR: next_s.fri_b = merge16(s.fri_b, avs_writedata_in, avs_byteenable_in);
          `G_GSA_ADDR:  next_s.gsa = merge16(s.gsa, avs_writedata_in, avs_byteenable_in);
          `G_GDA_ADDR:  next_s.gda = merge16(s.gda, avs_writedata_in, avs_byteenable_in);
          `G_GCR_ADDR:  next_s.gcr = merge16(s.gcr, avs_writedata_in, avs_byteenable_in);
          `G_GFR_ADDR: begin
            if (avs_byteenable_in[0]) begin
              next_s.gfr = avs_writedata_in[7:0];
            end
          end
          `G_CTRL_ADDR: begin
            if (avs_byteenable_in[0]) begin
              next_s.enable = avs_writedata_in[`CTRL_EN_LSB +: NCH];
            end
            if (avs_byteenable_in[1]) begin
              next_s.high_prio = avs_writedata_in[`CTRL_HI_LSB +: NCH];
            end
          end
          default: next_s.ack = bus_do;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      s          <= '0;
      s.frames   <= {NCH{`RST_FRAME}};
      s.gfr      <= `RST_FRAME;
      s.gcr      <= `RST_WORD;
      s.st       <= ST_IDLE;
    end else if (ce_in) begin
      s <= next_s;
    end
  end

endmodule : multichannel_dma_transfer_core

// ===== test/dma_core_chk.sv
// port assertions of the dma transfer core
module dma_core_chk (
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic        avs_waitrequest_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic        mem_read_out,
  input wire logic        mem_write_out,
  input wire logic [15:0] mem_wdata_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic        mem_ready_in,
  input wire logic [5:0]  channel_irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // completed memory accesses
  wire rd_done = mem_read_out && mem_ready_in;
  wire wr_done = mem_write_out && mem_ready_in;
  // register bus answers after exactly one wait
  bus_first_wait_a: assert property (
    $rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("bus request answered without wait");
  bus_one_wait_a: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus wait longer than one cycle");
  // element moves as read then write
  mem_excl_a: assert property (!(mem_read_out && mem_write_out))
    else $error("read and write together");
  read_then_write_a: assert property (
    rd_done |=> mem_write_out && !mem_read_out)
    else $error("write does not follow read");
  wdata_from_read_a: assert property (
    rd_done |=> mem_wdata_out == $past(mem_rdata_in))
    else $error("write data differs from read data");
  addr_hold_a: assert property (
    (mem_read_out || mem_write_out) && !mem_ready_in |=> $stable(mem_addr_out))
    else $error("address moved during access");
  write_end_a: assert property (wr_done |=> !mem_write_out)
    else $error("write held after completion");
  // interrupts are one-cycle pulses after a completed write
  irq_cause_a: assert property (|channel_irq_out |-> $past(wr_done))
    else $error("interrupt without completed write");
  irq_pulse_a: assert property (
    |channel_irq_out |=> (channel_irq_out & $past(channel_irq_out)) == 6'h00)
    else $error("interrupt longer than one cycle");
  // main scenarios reached
  cover property (rd_done);
  cover property (|channel_irq_out);
  cover property (mem_read_out && !mem_ready_in ##1 mem_read_out);
endmodule : dma_core_chk

// ===== test/dma_mem_model.sv
// memory model answering the core's transfers, fast or with stalls
module dma_mem_model (
  input  wire logic        clk_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        slow_in,
  output logic      [15:0] rdata_out,
  output logic             ready_out
);
  logic [15:0] m [256];
  logic [1:0]  stall;
  // flat word store filled with an address pattern
  initial begin
    for (int i = 0; i < 256; i++) begin
      m[i] = {8'hC3, 8'(i)};
    end
    stall = 2'h0;
    ready_out = 1'b0;
    rdata_out = 16'h0000;
  end
  // one answer per access; read data only valid with ready
  always @(posedge clk_in) begin
    ready_out <= 1'b0;
    rdata_out <= ~rdata_out;  // released bus keeps moving
    if ((read_in || write_in) && !ready_out) begin
      if (stall != 2'h0) begin
        stall <= stall - 2'h1;
      end else begin
        ready_out <= 1'b1;
        stall <= slow_in ? 2'h2 : 2'h0;
        if (read_in) rdata_out <= m[addr_in[7:0]];
        if (write_in) m[addr_in[7:0]] <= wdata_in;
      end
    end
  end
endmodule : dma_mem_model

// ===== test/multichannel_dma_transfer_core_bench.sv
// self-checking bench of the six-channel dma transfer core
module multichannel_dma_transfer_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        rd = 1'b0, wr = 1'b0, slow = 1'b0, tmr = 1'b0, mrdy, mr, mw, wt;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wd = 32'h0, rdv, q;
  logic [15:0] ma, mwd, mrd;
  logic [5:0]  irq;
  int          n_errors = 0, compares = 0, nirq = 0, k;
  logic [15:0] sx [6] = '{16'h40, 16'h42, 16'h44, 16'h49, 16'h4B, 16'h4D};
  `define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
  // 250 MHz clock and interrupt pulse count
  always #2 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) nirq <= nirq + $countones(irq);
  multichannel_dma_transfer_core dut (.clk_sys_in, .reset_in, .ce_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdv), .avs_waitrequest_out(wt),
    .mem_addr_out(ma), .mem_read_out(mr), .mem_write_out(mw), .mem_wdata_out(mwd),
    .mem_rdata_in(mrd), .mem_ready_in(mrdy), .serial_rx_event_in(3'h0),
    .serial_tx_event_in(3'h0), .timer_event_in(tmr), .ext_irq3_event_in(1'b0),
    .channel_irq_out(irq));
  dma_mem_model mem (.clk_in(clk_sys_in), .read_in(mr), .write_in(mw), .addr_in(ma),
    .wdata_in(mwd), .slow_in(slow), .rdata_out(mrd), .ready_out(mrdy));
  function automatic logic [15:0] pat(input int a);
    return {8'hC3, 8'(a)};
  endfunction : pat
  // one avalon access, held until waitrequest is low
  task automatic bus(input logic w, input logic [9:0] a, input logic [15:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    @(posedge clk_sys_in);
    while (wt !== 1'b0) @(posedge clk_sys_in);
    q = rdv;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus
  task automatic cfg(input int c, input logic [15:0] s, t, n, f, m);
    bus(1, 10'(c * 32), s);
    bus(1, 10'(c * 32 + 4), t);
    bus(1, 10'(c * 32 + 8), n);
    bus(1, 10'(c * 32 + 12), f);
    bus(1, 10'(c * 32 + 16), m);
  endtask : cfg
  // poll status until the channel's enable drops
  task automatic wait_off(input int c);
    for (int i = 0; i < 300; i++) begin
      bus(0, 10'h0E4, 16'h0000);
      if (q[c] === 1'b0) break;
    end
    `CHK(q[c], 1'b0)
  endtask : wait_off
  task automatic print_verdict;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    // reset values, priority readback, unmapped word
    bus(0, 10'h00C, 16'h0000);
    `CHK(q, 32'h0)
    bus(1, 10'h0E0, 16'h3F00);
    bus(0, 10'h0E0, 16'h0000);
    `CHK(q, 32'h3F00)
    bus(1, 10'h0E0, 16'h0000);
    bus(1, 10'h0C0, 16'h0002);
    bus(1, 10'h0C8, 16'h0005);
    bus(0, 10'h0C0, 16'h0000);
    `CHK(q, 32'h2)
    bus(1, 10'h0E8, 16'hFFFF);
    bus(0, 10'h0E8, 16'h0000);
    `CHK(q, 32'h0)
    // incrementing source into decrementing destination, end interrupt
    k = nirq;
    cfg(0, 16'h0010, 16'h0083, 16'h0003, 16'h0000, 16'h4108);
    bus(1, 10'h0E0, 16'h0001);
    wait_off(0);
    `CHK(nirq - k, 1)
    for (int i = 0; i < 4; i++) `CHK(mem.m[8'h83 - i], pat(8'h10 + i))
    // indexed source, two frames, stalling memory, interrupt disabled
    slow <= 1'b1;
    k = nirq;
    cfg(1, 16'h0040, 16'h0090, 16'h0002, 16'h0001, 16'h0304);
    bus(1, 10'h0E0, 16'h0002);
    wait_off(1);
    `CHK(nirq - k, 0)
    for (int i = 0; i < 6; i++) `CHK(mem.m[8'h90 + i], pat(sx[i]))
    // double word, two elements
    slow <= 1'b0;
    cfg(2, 16'h0060, 16'h00A0, 16'h0001, 16'h0000, 16'h0904);
    bus(1, 10'h0E0, 16'h0004);
    wait_off(2);
    for (int i = 0; i < 4; i++) `CHK(mem.m[8'hA0 + i], pat(8'h60 + i))
    // auto_reload_enable with a reload changed mid-block
    bus(1, 10'h0D0, 16'h0030);
    bus(1, 10'h0D4, 16'h00C0);
    bus(1, 10'h0D8, 16'h0001);
    cfg(3, 16'h0020, 16'h00B0, 16'h0001, 16'h0000, 16'h8104);
    bus(1, 10'h0E0, 16'h0008);
    bus(1, 10'h0D0, 16'h0050);
    repeat (100) @(posedge clk_sys_in);
    bus(0, 10'h0E4, 16'h0000);
    `CHK(q[3], 1'b1)
    bus(1, 10'h0E0, 16'h0000);
    for (int i = 0; i < 2; i++) begin
      `CHK(mem.m[8'hB0 + i], pat(8'h20 + i))
      `CHK(mem.m[8'hC0 + i], pat(8'h50 + i))
    end
    // timer-paced single element
    cfg(4, 16'h0070, 16'h00D0, 16'h0000, 16'hD000, 16'h0104);
    bus(1, 10'h0E0, 16'h0010);
    repeat (20) @(posedge clk_sys_in);
    bus(0, 10'h0E4, 16'h0000);
    `CHK(q[4], 1'b1)
    tmr <= 1'b1;
    @(posedge clk_sys_in);
    tmr <= 1'b0;
    wait_off(4);
    `CHK(mem.m[8'hD0], pat(8'h70))
    // auto-buffering on timer events: half and full buffer interrupts
    k = nirq;
    cfg(4, 16'h0000, 16'h00E0, 16'h0003, 16'hD000, 16'h7104);
    bus(1, 10'h0E0, 16'h0010);
    for (int i = 0; i < 4; i++) begin
      tmr <= 1'b1;
      @(posedge clk_sys_in);
      tmr <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
    end
    bus(1, 10'h0E0, 16'h0000);
    `CHK(nirq - k, 2)
    `CHK(mem.m[8'hE3], pat(8'h03))
    // interrupt at every frame end, two frames
    k = nirq;
    cfg(5, 16'h0000, 16'h00E8, 16'h0000, 16'h0001, 16'h6104);
    bus(1, 10'h0E0, 16'h0020);
    wait_off(5);
    `CHK(nirq - k, 2)
    // high channel 5 goes before low channel 0 onto one word
    cfg(0, 16'h0001, 16'h00F0, 16'h0000, 16'h0000, 16'h0000);
    cfg(5, 16'h0005, 16'h00F0, 16'h0000, 16'h0000, 16'h0000);
    bus(1, 10'h0E0, 16'h2021);
    wait_off(0);
    `CHK(mem.m[8'hF0], pat(8'h01))
    // equal priority: channels 1 and 2 take turns
    cfg(1, 16'h0011, 16'h00F1, 16'h0001, 16'h0000, 16'h0000);
    cfg(2, 16'h0012, 16'h00F1, 16'h0000, 16'h0000, 16'h0000);
    bus(1, 10'h0E0, 16'h0006);
    wait_off(1);
    `CHK(mem.m[8'hF1], pat(8'h11))
    print_verdict();
  end
endmodule : multichannel_dma_transfer_core_bench
bind multichannel_dma_transfer_core dma_core_chk chk (.clk_sys_in, .reset_in,
  .avs_read_in, .avs_write_in, .avs_waitrequest_out, .mem_addr_out, .mem_read_out,
  .mem_write_out, .mem_wdata_out, .mem_rdata_in, .mem_ready_in, .channel_irq_out);
